// [verilog/bpio_defines.vh]
`ifndef BPIO_DEFINES_VH
`define BPIO_DEFINES_VH
// Port and line counts.
`define BPIO_NUM_PORTS 12
`define BPIO_PORT_W 8
`define BPIO_NUM_LINES 96
// Vector depth per synchronous port.
`define BPIO_VEC_DEPTH 256
`define BPIO_VEC_AW 8
// Host operation codes.
`define BPIO_OP_W 3
`define BPIO_OP_WRITE 3'h0
`define BPIO_OP_READ 3'h1
`define BPIO_OP_LAST 3'h2
`define BPIO_OP_CFG 3'h3
`define BPIO_OP_SETSYNC 3'h4
`define BPIO_OP_LOADVEC 3'h5
`define BPIO_OP_ARM 3'h6
`define BPIO_OP_DISARM 3'h7
// Reset value of every output latch: all drivers off.
`define BPIO_OUT_RST 8'hFF
`endif

// [verilog/bpio_top.v]
`timescale 1ns/1ps
`default_nettype none
`include "bpio_defines.vh"

// Host side takes one request per strobe and answers one cycle later.
// Line side drives only lows; a released line reads whatever the pins show.
module bpio_top #(
  parameter NUM_PORTS = `BPIO_NUM_PORTS,
  parameter VEC_DEPTH = `BPIO_VEC_DEPTH
) (
  input wire clk,
  input wire nrst,
  input wire req_valid,
  input wire [`BPIO_OP_W-1:0] req_op,
  input wire [3:0] req_port,
  input wire [7:0] req_data,
  input wire req_dir_rd,
  output reg rsp_valid_ff,
  output reg rsp_error_ff,
  output reg [7:0] rsp_data_ff,
  input wire [`BPIO_NUM_LINES-1:0] line_in,
  output reg [`BPIO_NUM_LINES-1:0] line_out_ff,
  output reg [`BPIO_NUM_LINES-1:0] line_oe_ff,
  input wire step_clk_in,
  output reg busy_ff,
  output reg armed_ff
);
  // Channel n (1-based) is bit (n-1): port p holds bits 8p+7..8p.
  // Line synchroniser stages and the accepted, filtered line levels.
  reg [`BPIO_NUM_LINES-1:0] lin_s1_ff, lin_s2_ff, lin_s3_ff, lin_st_ff;
  // Step clock synchroniser and its accepted level.
  reg [2:0] clk_sync_ff;
  reg clk_st_ff;

  // Output latches, one bit per line; a one releases the line.
  reg [`BPIO_NUM_LINES-1:0] outreg_ff;
  // Last data written to or read from each port.
  reg [`BPIO_NUM_LINES-1:0] last_ff;

  // Synchronous group size and the per-port step direction.
  reg [3:0] nsync_ff;
  reg [`BPIO_NUM_PORTS-1:0] dir_rd_ff;
  // Step counter, last loaded vector index and the shared load index.
  reg [7:0] vec_cnt_ff;
  reg [7:0] vec_len_ff;
  reg [7:0] vec_idx_ff;
  // Vector bytes, one block of VEC_DEPTH entries per port.
  reg [7:0] vmem [0:NUM_PORTS*VEC_DEPTH-1];
  wire [11:0] vaddr_w;
  wire clk_rise_w;
  // Loop indices; each process owns its own.
  integer i;
  integer k;

  assign vaddr_w = {req_port, vec_idx_ff};
  // A step is counted on a stable rising edge of the filtered clock.
  assign clk_rise_w = (clk_sync_ff[1] == clk_sync_ff[2]) && clk_sync_ff[2] && !clk_st_ff;

  // Three-stage synchronisers; a level is accepted once stages two and three agree.
  always @(posedge clk) begin
    lin_s1_ff <= line_in;
    lin_s2_ff <= lin_s1_ff;
    lin_s3_ff <= lin_s2_ff;
    clk_sync_ff <= {clk_sync_ff[1:0], step_clk_in};
    if (!nrst) begin
      lin_st_ff <= {`BPIO_NUM_LINES{1'b1}};
      clk_st_ff <= 1'b0;
    end else begin
      // Each line bit is filtered on its own.
      for (i = 0; i < `BPIO_NUM_LINES; i = i + 1) begin
        if (lin_s2_ff[i] == lin_s3_ff[i])
          lin_st_ff[i] <= lin_s3_ff[i];
      end
      // The step clock is filtered the same way.
      if (clk_sync_ff[1] == clk_sync_ff[2])
        clk_st_ff <= clk_sync_ff[2];
    end
  end

  // Vector memory; one byte per port and step, loaded by the host.
  // Only an accepted load writes, so a refused one leaves the vectors alone.
  always @(posedge clk) begin
    if (req_valid && !armed_ff && req_op == `BPIO_OP_LOADVEC && req_port < nsync_ff)
      vmem[vaddr_w] <= req_data;
  end

  // Host command handling and synchronous stepping.
  // Reset leaves every port asynchronous with its lines released.
  always @(posedge clk) begin
    if (!nrst) begin
      outreg_ff <= {`BPIO_NUM_PORTS{`BPIO_OUT_RST}};
      last_ff <= {`BPIO_NUM_LINES{1'b1}};
      nsync_ff <= 4'h0;
      dir_rd_ff <= {`BPIO_NUM_PORTS{1'b0}};
      vec_cnt_ff <= 8'h00;
      vec_len_ff <= 8'h00;
      vec_idx_ff <= 8'h00;
      armed_ff <= 1'b0;
      busy_ff <= 1'b0;
      rsp_valid_ff <= 1'b0;
      rsp_error_ff <= 1'b0;
      rsp_data_ff <= 8'h00;
    end else begin
      // Every request is answered next cycle; error and data pulse for one cycle.
      rsp_valid_ff <= req_valid;
      rsp_error_ff <= 1'b0;
      rsp_data_ff <= 8'h00;
      busy_ff <= 1'b0;
      if (req_valid) begin
        case (req_op)
          // Whole-port write; refused while armed or past the last port.
          `BPIO_OP_WRITE: begin
            if (armed_ff || req_port >= NUM_PORTS) begin
              rsp_error_ff <= 1'b1;
            end else begin
              outreg_ff[req_port*8 +: 8] <= req_data;
              last_ff[req_port*8 +: 8] <= req_data;
            end
          end
          // Live read of the filtered levels; sync ports are not readable.
          `BPIO_OP_READ: begin
            if (armed_ff || req_port >= NUM_PORTS || req_port < nsync_ff) begin
              rsp_error_ff <= 1'b1;
            end else begin
              rsp_data_ff <= lin_st_ff[req_port*8 +: 8];
              last_ff[req_port*8 +: 8] <= lin_st_ff[req_port*8 +: 8];
            end
          end
          // Data query: the byte last written to or read from the port.
          `BPIO_OP_LAST: begin
            if (req_port >= NUM_PORTS)
              rsp_error_ff <= 1'b1;
            else
              rsp_data_ff <= last_ff[req_port*8 +: 8];
          end
          // Setup query: armed flag on top, group size at the bottom.
          `BPIO_OP_CFG: begin
            rsp_data_ff <= {armed_ff, 3'h0, nsync_ff};
          end
          // Group size; ports below it step, those at or above it stay asynchronous.
          `BPIO_OP_SETSYNC: begin
            if (armed_ff || req_data[3:0] > NUM_PORTS) begin
              rsp_error_ff <= 1'b1;
            end else begin
              nsync_ff <= req_data[3:0];
              vec_len_ff <= 8'h00;
            end
          end
          // Vector load at the shared index, which then moves on.
          `BPIO_OP_LOADVEC: begin
            if (armed_ff || req_port >= nsync_ff) begin
              rsp_error_ff <= 1'b1;
            end else begin
              dir_rd_ff[req_port] <= req_dir_rd;
              vec_idx_ff <= vec_idx_ff + 8'h01;
              if (vec_idx_ff >= vec_len_ff)
                vec_len_ff <= vec_idx_ff;
            end
          end
          // Arming needs a group and restarts both counters.
          `BPIO_OP_ARM: begin
            if (armed_ff || nsync_ff == 4'h0) begin
              rsp_error_ff <= 1'b1;
            end else begin
              armed_ff <= 1'b1;
              vec_cnt_ff <= 8'h00;
              vec_idx_ff <= 8'h00;
            end
          end
          // Disarm is always taken and stops stepping at once.
          `BPIO_OP_DISARM: begin
            armed_ff <= 1'b0;
            vec_idx_ff <= 8'h00;
          end
          default: rsp_error_ff <= 1'b1;
        endcase
      end else if (armed_ff && clk_rise_w) begin
        // One step on all synchronous ports at once.
        busy_ff <= 1'b1;
        for (k = 0; k < `BPIO_NUM_PORTS; k = k + 1) begin
          if (k < nsync_ff) begin
            // A reading port captures its lines; a writing port drives its next byte.
            if (dir_rd_ff[k])
              last_ff[k*8 +: 8] <= lin_st_ff[k*8 +: 8];
            else begin
              outreg_ff[k*8 +: 8] <= vmem[{k[3:0], vec_cnt_ff}];
              last_ff[k*8 +: 8] <= vmem[{k[3:0], vec_cnt_ff}];
            end
          end
        end
        // The last loaded vector disarms the group by itself.
        vec_cnt_ff <= vec_cnt_ff + 8'h01;
        if (vec_cnt_ff == vec_len_ff)
          armed_ff <= 1'b0;
      end
    end
  end

  // Open-collector drive: enable only where the latch holds zero.
  always @(posedge clk) begin
    if (!nrst) begin
      line_out_ff <= {`BPIO_NUM_LINES{1'b0}};
      line_oe_ff <= {`BPIO_NUM_LINES{1'b0}};
    end else begin
      // The data side of every driver is tied low; only the enable moves.
      line_out_ff <= {`BPIO_NUM_LINES{1'b0}};
      // A latch bit of one turns its driver off, so that line serves as an input.
      line_oe_ff <= ~outreg_ff;
    end
  end
endmodule // bpio_top
`default_nettype wire

// [dv/bpio_ext.sv]
`timescale 1ns/1ps
`default_nettype none
module bpio_ext (
  input wire logic [95:0] line_oe_ff,
  input wire logic [95:0] ext_low,
  output logic [95:0] line_in
);
  // A line sinks low if either side pulls it, else the pull-up wins.
  assign line_in = ~(line_oe_ff | ext_low);
endmodule // bpio_ext
`default_nettype wire

// [dv/bpio_chk.sv]
`timescale 1ns/1ps
`default_nettype none
`include "bpio_defines.vh"
module bpio_chk (
  input wire logic clk,
  input wire logic nrst,
  input wire logic req_valid,
  input wire logic [2:0] req_op,
  input wire logic [3:0] req_port,
  input wire logic [7:0] req_data,
  input wire logic rsp_valid_ff,
  input wire logic rsp_error_ff,
  input wire logic [7:0] rsp_data_ff,
  input wire logic [95:0] line_out_ff,
  input wire logic [95:0] line_oe_ff,
  input wire logic armed_ff,
  input wire logic busy_ff
);
  // All checks share one clock and the synchronous reset.
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_ans; req_valid |=> rsp_valid_ff; endproperty
  a_ans: assert property (p_ans) else $error("missing answer");
  property p_quiet; !req_valid |=> !rsp_valid_ff; endproperty
  a_quiet: assert property (p_quiet) else $error("stray answer");
  property p_oc; line_out_ff == 96'h0; endproperty
  a_oc: assert property (p_oc) else $error("line driven high");
  property p_rst; $rose(nrst) |-> line_oe_ff == 96'h0 && !armed_ff; endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_armrd; armed_ff && req_valid && req_op == `BPIO_OP_READ |=> rsp_error_ff; endproperty
  a_armrd: assert property (p_armrd) else $error("read accepted while armed");
  property p_range; req_valid && req_op == `BPIO_OP_WRITE && req_port > 4'hB |=> rsp_error_ff; endproperty
  a_range: assert property (p_range) else $error("bad port accepted");
  property p_grp; req_valid && req_op == `BPIO_OP_SETSYNC && req_data[3:0] > 4'hC |=> rsp_error_ff; endproperty
  a_grp: assert property (p_grp) else $error("sync count accepted");
  property p_wr;
    req_valid && req_op == `BPIO_OP_WRITE && req_port == 4'h0 && !armed_ff
      |=> ##1 line_oe_ff[7:0] == ~$past(req_data, 2);
  endproperty
  a_wr: assert property (p_wr) else $error("port 0 drivers wrong");
  property p_cfg; req_valid && req_op == `BPIO_OP_CFG |=> !rsp_error_ff && rsp_data_ff[6:4] == 3'h0; endproperty
  a_cfg: assert property (p_cfg) else $error("bad setup answer");
  property p_armwr; armed_ff && req_valid && req_op == `BPIO_OP_WRITE |=> rsp_error_ff; endproperty
  a_armwr: assert property (p_armwr) else $error("write accepted while armed");
  property p_busy; busy_ff |-> $past(armed_ff) && !$past(req_valid); endproperty
  a_busy: assert property (p_busy) else $error("step taken when not allowed");
endmodule // bpio_chk
`default_nettype wire

// [dv/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "bpio_defines.vh"
module testbench;
  logic clk = 0, nrst = 0, req_valid = 0, req_dir_rd = 0, step_clk_in = 0, r_err;
  logic [2:0] req_op = 0;
  logic [3:0] req_port = 0;
  logic [7:0] req_data = 0, r_data;
  logic [95:0] ext_low = 0;
  wire [95:0] line_in, line_out_ff, line_oe_ff;
  wire rsp_valid_ff, rsp_error_ff, busy_ff, armed_ff;
  wire [7:0] rsp_data_ff;
  int fails = 0, total_checks = 0, cyc = 0;
  logic [7:0] busy_cnt = 0;
  // Counts step pulses seen on the busy output.
  always @(posedge clk) begin
    if (busy_ff)
      busy_cnt <= busy_cnt + 8'h01;
  end
  // Clock, design and far-side lines.
  always #12.5 clk = ~clk;
  bpio_top u_dut (.clk, .nrst, .req_valid, .req_op, .req_port, .req_data, .req_dir_rd,
    .rsp_valid_ff, .rsp_error_ff, .rsp_data_ff, .line_in, .line_out_ff, .line_oe_ff,
    .step_clk_in, .busy_ff, .armed_ff);
  bpio_ext u_ext (.line_oe_ff, .ext_low, .line_in);
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    if (fails == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // One request cycle, then capture the answer.
  task automatic req(input logic [2:0] op, input logic [3:0] p, input logic [7:0] d,
    input logic rd = 1'b0);
    @(posedge clk);
    req_valid <= 1;
    req_op <= op;
    req_port <= p;
    req_data <= d;
    req_dir_rd <= rd;
    @(posedge clk);
    req_valid <= 0;
    #1;
    r_err = rsp_error_ff;
    r_data = rsp_data_ff;
  endtask
  task automatic step;
    @(posedge clk);
    step_clk_in <= 1;
    repeat (8) @(posedge clk);
    step_clk_in <= 0;
    repeat (8) @(posedge clk);
  endtask
  task automatic t_reset;
    chk(line_oe_ff[7:0], 8'h00);
    req(`BPIO_OP_CFG, 0, 0);
    chk(r_data, 8'h00);
  endtask
  task automatic t_async;
    req(`BPIO_OP_WRITE, 11, 8'h5A);
    ext_low[89] <= 1;
    repeat (6) @(posedge clk);
    chk(line_oe_ff[95:88], 8'hA5);
    req(`BPIO_OP_READ, 11, 0);
    chk(r_data, 8'h58);
    req(`BPIO_OP_LAST, 11, 0);
    chk(r_data, 8'h58);
    req(`BPIO_OP_WRITE, 12, 0);
    chk({7'h00, r_err}, 8'h01);
  endtask
  task automatic t_sync;
    req(`BPIO_OP_SETSYNC, 0, 8'h0D);
    chk({7'h00, r_err}, 8'h01);
    req(`BPIO_OP_SETSYNC, 0, 8'h01);
    req(`BPIO_OP_CFG, 0, 0);
    chk(r_data, 8'h01);
    req(`BPIO_OP_READ, 0, 0);
    chk({7'h00, r_err}, 8'h01);
    req(`BPIO_OP_LOADVEC, 0, 8'h00);
    req(`BPIO_OP_ARM, 0, 0);
    req(`BPIO_OP_WRITE, 5, 0);
    chk({7'h00, r_err}, 8'h01);
    req(`BPIO_OP_READ, 5, 0);
    chk({7'h00, r_err}, 8'h01);
    repeat (2) step;
    chk(line_oe_ff[7:0], 8'hFF);
    chk({7'h00, armed_ff}, 8'h00);
    chk(busy_cnt, 8'h01);
  endtask
  // Port 0 reads its lines on one external step.
  task automatic t_syncrd;
    req(`BPIO_OP_WRITE, 0, 8'hFF);
    chk({7'h00, r_err}, 8'h00);
    ext_low[7:0] <= 8'h3C;
    req(`BPIO_OP_LOADVEC, 0, 8'h00, 1'b1);
    req(`BPIO_OP_ARM, 0, 0);
    step;
    chk(busy_cnt, 8'h02);
    chk({7'h00, armed_ff}, 8'h00);
    chk(line_oe_ff[7:0], 8'h00);
    req(`BPIO_OP_LAST, 0, 0);
    chk(r_data, 8'hC3);
  endtask
  // A reset in mid-run while armed returns everything to asynchronous use.
  task automatic t_rst2;
    req(`BPIO_OP_WRITE, 0, 8'h00);
    req(`BPIO_OP_ARM, 0, 0);
    chk(line_oe_ff[7:0], 8'hFF);
    @(posedge clk);
    nrst <= 0;
    repeat (5) @(posedge clk);
    nrst <= 1;
    repeat (4) @(posedge clk);
    chk(line_oe_ff[7:0], 8'h00);
    req(`BPIO_OP_CFG, 0, 0);
    chk(r_data, 8'h00);
  endtask
  // Hang guard.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      end_of_test;
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1;
    repeat (4) @(posedge clk);
    t_reset;
    t_async;
    t_sync;
    t_syncrd;
    t_rst2;
    end_of_test;
  end
endmodule // testbench
bind bpio_top bpio_chk u_chk (.clk, .nrst, .req_valid, .req_op, .req_port, .req_data,
  .rsp_valid_ff, .rsp_error_ff, .rsp_data_ff, .line_out_ff, .line_oe_ff, .armed_ff, .busy_ff);
`default_nettype wire
